/* File: logic/mcbbcd_core.sv */
// CPU sequencer for jumps, branches, bit operations, control ops, add-with-carry and AND
`timescale 1ns/1ns
module mcbbcd_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] mem_rdata,
   input wire logic irq_pin,
   input wire logic wake_req,
   output logic [15:0] mem_addr_ff,
   output logic [7:0] mem_wdata_ff,
   output logic mem_rd_ff,
   output logic mem_wr_ff,
   output logic osc_stop_ff,
   output logic cpu_halt_ff,
   output logic irq_pin_en_ff,
   output logic unsup_op_ff,
   output logic [15:0] pc_ff,
   output logic [7:0] sp_ff,
   output logic [7:0] acc_ff,
   output logic [7:0] idx_ff,
   output logic [4:0] ccr_ff
);
   mcbbcd_pkg::mcbbcd_state_t state_ff, nxt_state;
   logic [7:0] op_ff, nxt_op;
   logic [7:0] b1_ff, nxt_b1;
   logic [7:0] b2_ff, nxt_b2;
   logic [1:0] cnt_ff, nxt_cnt;
   logic [7:0] data_ff, nxt_data;
   logic [15:0] ea_ff, nxt_ea;
   logic [2:0] stk_k_ff, nxt_stk_k;
   logic [2:0] stk_n_ff, nxt_stk_n;
   logic stk_pop_ff, nxt_stk_pop;
   logic [15:0] nxt_mem_addr, nxt_pc;
   logic [7:0] nxt_mem_wdata, nxt_sp, nxt_acc, nxt_idx;
   logic nxt_mem_rd, nxt_mem_wr, nxt_osc_stop, nxt_cpu_halt, nxt_irq_pin_en, nxt_unsup;
   logic [4:0] nxt_ccr;

   mcbbcd_pkg::mcbbcd_mode_t mode;
   mcbbcd_pkg::mcbbcd_alu_t alu_sel;
   logic [3:0] grp, lo;
   logic [1:0] need;
   logic is_brbit, is_bitop, is_branch, is_tst, is_adc, is_and, is_jmp, is_jsr;
   logic mem_opnd, br_cond, bit_val;
   logic [2:0] bit_no;
   logic [15:0] ea_c, sp_addr, sp_next_addr;
   logic [7:0] sp_dec, sp_inc, push_byte, bit_mask;
   logic [7:0] alu_res;
   logic alu_h, alu_n, alu_z, alu_c;

   always_comb begin
      grp = op_ff[7:4];
      lo = op_ff[3:0];
      bit_no = op_ff[3:1];
      bit_mask = 8'h01 << bit_no;
      is_brbit = (grp == mcbbcd_pkg::GRP_BRBIT);
      is_bitop = (grp == mcbbcd_pkg::GRP_BITOP);
      is_branch = (grp == mcbbcd_pkg::GRP_BRANCH);
      is_tst = (lo == mcbbcd_pkg::LO_TST) && (grp >= mcbbcd_pkg::GRP_TST_DIR) && (grp <= mcbbcd_pkg::GRP_TST_IX);
      is_adc = (lo == mcbbcd_pkg::LO_ADC) && (grp >= mcbbcd_pkg::GRP_IMM);
      is_and = (lo == mcbbcd_pkg::LO_AND) && (grp >= mcbbcd_pkg::GRP_IMM);
      is_jmp = (lo == mcbbcd_pkg::LO_JMP) && (grp >= mcbbcd_pkg::GRP_DIR);
      is_jsr = (lo == mcbbcd_pkg::LO_JSR) && (grp >= mcbbcd_pkg::GRP_DIR);
      unique case (grp)
         mcbbcd_pkg::GRP_BRBIT: mode = mcbbcd_pkg::M_BTB;
         mcbbcd_pkg::GRP_BITOP: mode = mcbbcd_pkg::M_DIR;
         mcbbcd_pkg::GRP_BRANCH: mode = mcbbcd_pkg::M_REL;
         mcbbcd_pkg::GRP_TST_DIR: mode = mcbbcd_pkg::M_DIR;
         mcbbcd_pkg::GRP_TST_IX1: mode = mcbbcd_pkg::M_IX1;
         mcbbcd_pkg::GRP_TST_IX: mode = mcbbcd_pkg::M_IX;
         mcbbcd_pkg::GRP_IMM: mode = mcbbcd_pkg::M_IMM;
         mcbbcd_pkg::GRP_DIR: mode = mcbbcd_pkg::M_DIR;
         mcbbcd_pkg::GRP_EXT: mode = mcbbcd_pkg::M_EXT;
         mcbbcd_pkg::GRP_IX2: mode = mcbbcd_pkg::M_IX2;
         mcbbcd_pkg::GRP_IX1: mode = mcbbcd_pkg::M_IX1;
         mcbbcd_pkg::GRP_IX: mode = mcbbcd_pkg::M_IX;
         default: mode = mcbbcd_pkg::M_INH;
      endcase
      // Two bytes follow a bit-test branch opcode: address, then displacement
      unique case (mode)
         mcbbcd_pkg::M_EXT, mcbbcd_pkg::M_IX2, mcbbcd_pkg::M_BTB: need = 2'h2;
         mcbbcd_pkg::M_IMM, mcbbcd_pkg::M_DIR, mcbbcd_pkg::M_IX1, mcbbcd_pkg::M_REL: need = 2'h1;
         default: need = 2'h0;
      endcase
      unique case (mode)
         mcbbcd_pkg::M_EXT: ea_c = {b1_ff, b2_ff};
         mcbbcd_pkg::M_IX2: ea_c = {b1_ff, b2_ff} + {8'h00, idx_ff};
         mcbbcd_pkg::M_IX1: ea_c = {8'h00, b1_ff} + {8'h00, idx_ff};
         mcbbcd_pkg::M_IX: ea_c = {8'h00, idx_ff};
         default: ea_c = {mcbbcd_pkg::PAGE_ZERO, b1_ff};
      endcase
      mem_opnd = is_bitop || is_brbit || ((is_adc || is_and) && (mode != mcbbcd_pkg::M_IMM)) ||
                 (is_tst && (mode != mcbbcd_pkg::M_INH));
      // Pairs of branch opcodes: even tests the condition, odd its inverse
      unique case (lo[3:1])
         3'h0: br_cond = 1'b1;
         3'h1: br_cond = !(ccr_ff[mcbbcd_pkg::CCR_C] || ccr_ff[mcbbcd_pkg::CCR_Z]);
         3'h2: br_cond = !ccr_ff[mcbbcd_pkg::CCR_C];
         3'h3: br_cond = !ccr_ff[mcbbcd_pkg::CCR_Z];
         3'h4: br_cond = !ccr_ff[mcbbcd_pkg::CCR_H];
         3'h5: br_cond = !ccr_ff[mcbbcd_pkg::CCR_N];
         3'h6: br_cond = !ccr_ff[mcbbcd_pkg::CCR_I];
         3'h7: br_cond = !irq_pin;
         default: br_cond = 1'b0;
      endcase
      br_cond = br_cond ^ lo[0];
      bit_val = |(data_ff & bit_mask);
      alu_sel = is_adc ? mcbbcd_pkg::ALU_ADC : (is_and ? mcbbcd_pkg::ALU_AND : mcbbcd_pkg::ALU_TST);
      // Stack lives in the top quarter of page zero
      sp_dec = {mcbbcd_pkg::SP_FIXED, sp_ff[5:0] - 6'h01};
      sp_inc = {mcbbcd_pkg::SP_FIXED, sp_ff[5:0] + 6'h01};
      sp_addr = {mcbbcd_pkg::PAGE_ZERO, sp_ff};
      sp_next_addr = {mcbbcd_pkg::PAGE_ZERO, sp_inc};
      unique case (stk_k_ff)
         3'h0: push_byte = pc_ff[7:0];
         3'h1: push_byte = pc_ff[15:8];
         3'h2: push_byte = idx_ff;
         3'h3: push_byte = acc_ff;
         default: push_byte = {mcbbcd_pkg::CCR_PAD, ccr_ff};
      endcase
   end

   mcbbcd_alu u_alu (
      .sel(alu_sel),
      .a(acc_ff),
      .m(data_ff),
      .cin(ccr_ff[mcbbcd_pkg::CCR_C]),
      .res(alu_res),
      .h(alu_h),
      .n(alu_n),
      .z(alu_z),
      .c(alu_c)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_b1 = b1_ff;
      nxt_b2 = b2_ff;
      nxt_cnt = cnt_ff;
      nxt_data = data_ff;
      nxt_ea = ea_ff;
      nxt_stk_k = stk_k_ff;
      nxt_stk_n = stk_n_ff;
      nxt_stk_pop = stk_pop_ff;
      nxt_mem_addr = mem_addr_ff;
      nxt_mem_wdata = mem_wdata_ff;
      nxt_mem_rd = 1'b0;
      nxt_mem_wr = 1'b0;
      nxt_osc_stop = osc_stop_ff;
      nxt_cpu_halt = cpu_halt_ff;
      nxt_irq_pin_en = irq_pin_en_ff;
      nxt_unsup = 1'b0;
      nxt_pc = pc_ff;
      nxt_sp = sp_ff;
      nxt_acc = acc_ff;
      nxt_idx = idx_ff;
      nxt_ccr = ccr_ff;
      unique case (state_ff)
         mcbbcd_pkg::S_FETCH: begin
            nxt_mem_addr = pc_ff;
            nxt_mem_rd = 1'b1;
            nxt_pc = pc_ff + 16'h0001;
            nxt_state = mcbbcd_pkg::S_DECODE;
         end
         mcbbcd_pkg::S_DECODE: begin
            nxt_op = mem_rdata;
            nxt_cnt = 2'h0;
            nxt_state = mcbbcd_pkg::S_OPND;
         end
         mcbbcd_pkg::S_OPND: begin
            if (cnt_ff == need) begin
               nxt_state = mcbbcd_pkg::S_ADDR;
            end else begin
               nxt_mem_addr = pc_ff;
               nxt_mem_rd = 1'b1;
               nxt_pc = pc_ff + 16'h0001;
               nxt_state = mcbbcd_pkg::S_OPCAP;
            end
         end
         mcbbcd_pkg::S_OPCAP: begin
            if (cnt_ff == 2'h0) begin
               nxt_b1 = mem_rdata;
            end else begin
               nxt_b2 = mem_rdata;
            end
            nxt_cnt = cnt_ff + 2'h1;
            nxt_state = mcbbcd_pkg::S_OPND;
         end
         mcbbcd_pkg::S_ADDR: begin
            nxt_ea = ea_c;
            nxt_state = mcbbcd_pkg::S_FETCH;
            if ((is_adc || is_and) && (mode == mcbbcd_pkg::M_IMM)) begin
               nxt_data = b1_ff;
               nxt_state = mcbbcd_pkg::S_EXEC;
            end else if (mem_opnd) begin
               nxt_state = mcbbcd_pkg::S_READ;
            end else if (is_tst) begin
               nxt_data = (grp == mcbbcd_pkg::GRP_TST_A) ? acc_ff : idx_ff;
               nxt_state = mcbbcd_pkg::S_EXEC;
            end else if (is_jmp) begin
               nxt_pc = ea_c;
            end else if (is_jsr) begin
               nxt_stk_k = 3'h0;
               nxt_stk_n = mcbbcd_pkg::STK_N_JSR;
               nxt_stk_pop = 1'b0;
               nxt_state = mcbbcd_pkg::S_STACK;
            end else if (is_branch) begin
               if (br_cond) begin
                  nxt_pc = pc_ff + {{8{b1_ff[7]}}, b1_ff};
               end
            end else begin
               // Control group: registers, run state and the RTS, RTI and SWI stack sequences
               unique case (op_ff)
                  mcbbcd_pkg::OP_CLC: nxt_ccr[mcbbcd_pkg::CCR_C] = 1'b0;
                  mcbbcd_pkg::OP_SEC: nxt_ccr[mcbbcd_pkg::CCR_C] = 1'b1;
                  mcbbcd_pkg::OP_CLI: nxt_ccr[mcbbcd_pkg::CCR_I] = 1'b0;
                  mcbbcd_pkg::OP_SEI: nxt_ccr[mcbbcd_pkg::CCR_I] = 1'b1;
                  mcbbcd_pkg::OP_RSP: nxt_sp = mcbbcd_pkg::SP_RESET;
                  mcbbcd_pkg::OP_NOP: nxt_state = mcbbcd_pkg::S_FETCH;
                  mcbbcd_pkg::OP_TAX: nxt_idx = acc_ff;
                  mcbbcd_pkg::OP_TXA: nxt_acc = idx_ff;
                  mcbbcd_pkg::OP_STOP: begin
                     nxt_osc_stop = 1'b1;
                     nxt_irq_pin_en = 1'b1;
                     nxt_state = mcbbcd_pkg::S_HALT;
                  end
                  mcbbcd_pkg::OP_WAIT: begin
                     nxt_cpu_halt = 1'b1;
                     nxt_ccr[mcbbcd_pkg::CCR_I] = 1'b0;
                     nxt_state = mcbbcd_pkg::S_HALT;
                  end
                  mcbbcd_pkg::OP_RTS, mcbbcd_pkg::OP_RTI: begin
                     nxt_stk_n = (op_ff == mcbbcd_pkg::OP_RTI) ? mcbbcd_pkg::STK_N_SWI : mcbbcd_pkg::STK_N_JSR;
                     nxt_stk_k = nxt_stk_n;
                     nxt_stk_pop = 1'b1;
                     nxt_state = mcbbcd_pkg::S_STACK;
                  end
                  mcbbcd_pkg::OP_SWI: begin
                     nxt_stk_k = 3'h0;
                     nxt_stk_n = mcbbcd_pkg::STK_N_SWI;
                     nxt_stk_pop = 1'b0;
                     nxt_state = mcbbcd_pkg::S_STACK;
                  end
                  default: nxt_unsup = 1'b1;
               endcase
            end
         end
         mcbbcd_pkg::S_READ: begin
            nxt_mem_addr = ea_ff;
            nxt_mem_rd = 1'b1;
            nxt_state = mcbbcd_pkg::S_RDCAP;
         end
         mcbbcd_pkg::S_RDCAP: begin
            nxt_data = mem_rdata;
            nxt_state = mcbbcd_pkg::S_EXEC;
         end
         mcbbcd_pkg::S_EXEC: begin
            nxt_state = mcbbcd_pkg::S_FETCH;
            if (is_adc || is_and) begin
               nxt_acc = alu_res;
               nxt_ccr[mcbbcd_pkg::CCR_N] = alu_n;
               nxt_ccr[mcbbcd_pkg::CCR_Z] = alu_z;
               if (is_adc) begin
                  nxt_ccr[mcbbcd_pkg::CCR_H] = alu_h;
                  nxt_ccr[mcbbcd_pkg::CCR_C] = alu_c;
               end
            end else if (is_tst) begin
               // Flags only; nothing is written back
               nxt_ccr[mcbbcd_pkg::CCR_N] = alu_n;
               nxt_ccr[mcbbcd_pkg::CCR_Z] = alu_z;
            end else if (is_bitop) begin
               nxt_mem_addr = ea_ff;
               nxt_mem_wdata = op_ff[0] ? (data_ff & ~bit_mask) : (data_ff | bit_mask);
               nxt_mem_wr = 1'b1;
            end else begin
               nxt_ccr[mcbbcd_pkg::CCR_C] = bit_val;
               if (bit_val ^ op_ff[0]) begin
                  nxt_pc = pc_ff + {{8{b2_ff[7]}}, b2_ff};
               end
            end
         end
         mcbbcd_pkg::S_STACK: begin
            if (!stk_pop_ff && (stk_k_ff != stk_n_ff)) begin
               nxt_mem_addr = sp_addr;
               nxt_mem_wdata = push_byte;
               nxt_mem_wr = 1'b1;
               nxt_sp = sp_dec;
               nxt_stk_k = stk_k_ff + 3'h1;
            end else if (stk_pop_ff && (stk_k_ff != 3'h0)) begin
               nxt_mem_addr = sp_next_addr;
               nxt_mem_rd = 1'b1;
               nxt_sp = sp_inc;
               nxt_state = mcbbcd_pkg::S_STKCAP;
            end else if (is_jsr) begin
               nxt_pc = ea_ff;
               nxt_state = mcbbcd_pkg::S_FETCH;
            end else if (op_ff == mcbbcd_pkg::OP_SWI) begin
               nxt_ccr[mcbbcd_pkg::CCR_I] = 1'b1;
               nxt_stk_k = 3'h0;
               nxt_state = mcbbcd_pkg::S_VECT;
            end else begin
               nxt_state = mcbbcd_pkg::S_FETCH;
            end
         end
         mcbbcd_pkg::S_STKCAP: begin
            unique case (stk_k_ff)
               3'h1: nxt_pc = {pc_ff[15:8], mem_rdata};
               3'h2: nxt_pc = {mem_rdata, pc_ff[7:0]};
               3'h3: nxt_idx = mem_rdata;
               3'h4: nxt_acc = mem_rdata;
               default: nxt_ccr = mem_rdata[4:0];
            endcase
            nxt_stk_k = stk_k_ff - 3'h1;
            nxt_state = mcbbcd_pkg::S_STACK;
         end
         mcbbcd_pkg::S_VECT: begin
            if (stk_k_ff[1:0] == mcbbcd_pkg::VEC_BYTES) begin
               nxt_state = mcbbcd_pkg::S_FETCH;
            end else begin
               nxt_mem_addr = mcbbcd_pkg::SWI_VEC_ADDR + {14'h0000, stk_k_ff[1:0]};
               nxt_mem_rd = 1'b1;
               nxt_state = mcbbcd_pkg::S_VCAP;
            end
         end
         mcbbcd_pkg::S_VCAP: begin
            if (stk_k_ff == 3'h0) begin
               nxt_pc = {mem_rdata, pc_ff[7:0]};
            end else begin
               nxt_pc = {pc_ff[15:8], mem_rdata};
            end
            nxt_stk_k = stk_k_ff + 3'h1;
            nxt_state = mcbbcd_pkg::S_VECT;
         end
         mcbbcd_pkg::S_HALT: begin
            // No interrupt service here; wake simply resumes fetch
            if (wake_req) begin
               nxt_osc_stop = 1'b0;
               nxt_cpu_halt = 1'b0;
               nxt_irq_pin_en = 1'b0;
               nxt_state = mcbbcd_pkg::S_FETCH;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= mcbbcd_pkg::S_FETCH;
         op_ff <= 8'h00;
         b1_ff <= 8'h00;
         b2_ff <= 8'h00;
         cnt_ff <= 2'h0;
         data_ff <= 8'h00;
         ea_ff <= 16'h0000;
         stk_k_ff <= 3'h0;
         stk_n_ff <= 3'h0;
         stk_pop_ff <= 1'b0;
         mem_addr_ff <= 16'h0000;
         mem_wdata_ff <= 8'h00;
         mem_rd_ff <= 1'b0;
         mem_wr_ff <= 1'b0;
         osc_stop_ff <= 1'b0;
         cpu_halt_ff <= 1'b0;
         irq_pin_en_ff <= 1'b0;
         unsup_op_ff <= 1'b0;
         pc_ff <= mcbbcd_pkg::PC_RESET;
         sp_ff <= mcbbcd_pkg::SP_RESET;
         acc_ff <= 8'h00;
         idx_ff <= 8'h00;
         ccr_ff <= mcbbcd_pkg::CCR_RESET;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         b1_ff <= nxt_b1;
         b2_ff <= nxt_b2;
         cnt_ff <= nxt_cnt;
         data_ff <= nxt_data;
         ea_ff <= nxt_ea;
         stk_k_ff <= nxt_stk_k;
         stk_n_ff <= nxt_stk_n;
         stk_pop_ff <= nxt_stk_pop;
         mem_addr_ff <= nxt_mem_addr;
         mem_wdata_ff <= nxt_mem_wdata;
         mem_rd_ff <= nxt_mem_rd;
         mem_wr_ff <= nxt_mem_wr;
         osc_stop_ff <= nxt_osc_stop;
         cpu_halt_ff <= nxt_cpu_halt;
         irq_pin_en_ff <= nxt_irq_pin_en;
         unsup_op_ff <= nxt_unsup;
         pc_ff <= nxt_pc;
         sp_ff <= nxt_sp;
         acc_ff <= nxt_acc;
         idx_ff <= nxt_idx;
         ccr_ff <= nxt_ccr;
      end
   end
endmodule

/* File: logic/mcbbcd_pkg.sv */
// Opcode, state, mode and constant definitions for the branch, bit and control decoder
package mcbbcd_pkg;
   typedef enum logic [3:0] {
      S_FETCH  = 4'h0,
      S_DECODE = 4'h1,
      S_OPND   = 4'h2,
      S_OPCAP  = 4'h3,
      S_ADDR   = 4'h4,
      S_READ   = 4'h5,
      S_RDCAP  = 4'h6,
      S_EXEC   = 4'h7,
      S_STACK  = 4'h8,
      S_STKCAP = 4'h9,
      S_VECT   = 4'ha,
      S_VCAP   = 4'hb,
      S_HALT   = 4'hc
   } mcbbcd_state_t;

   typedef enum logic [3:0] {
      M_INH = 4'h0,
      M_IMM = 4'h1,
      M_DIR = 4'h2,
      M_EXT = 4'h3,
      M_IX2 = 4'h4,
      M_IX1 = 4'h5,
      M_IX  = 4'h6,
      M_REL = 4'h7,
      M_BTB = 4'h8
   } mcbbcd_mode_t;

   typedef enum logic [1:0] {
      ALU_ADC = 2'h0,
      ALU_AND = 2'h1,
      ALU_TST = 2'h2
   } mcbbcd_alu_t;

   // Opcode groups in the high nibble
   localparam logic [3:0] GRP_BRBIT = 4'h0;
   localparam logic [3:0] GRP_BITOP = 4'h1;
   localparam logic [3:0] GRP_BRANCH = 4'h2;
   localparam logic [3:0] GRP_TST_DIR = 4'h3;
   localparam logic [3:0] GRP_TST_A = 4'h4;
   localparam logic [3:0] GRP_TST_X = 4'h5;
   localparam logic [3:0] GRP_TST_IX1 = 4'h6;
   localparam logic [3:0] GRP_TST_IX = 4'h7;
   localparam logic [3:0] GRP_CTL8 = 4'h8;
   localparam logic [3:0] GRP_CTL9 = 4'h9;
   localparam logic [3:0] GRP_IMM = 4'ha;
   localparam logic [3:0] GRP_DIR = 4'hb;
   localparam logic [3:0] GRP_EXT = 4'hc;
   localparam logic [3:0] GRP_IX2 = 4'hd;
   localparam logic [3:0] GRP_IX1 = 4'he;
   localparam logic [3:0] GRP_IX = 4'hf;
   // Low nibbles
   localparam logic [3:0] LO_ADC = 4'h9;
   localparam logic [3:0] LO_AND = 4'h4;
   localparam logic [3:0] LO_TST = 4'hd;
   localparam logic [3:0] LO_JMP = 4'hc;
   localparam logic [3:0] LO_JSR = 4'hd;
   // Control opcodes
   localparam logic [7:0] OP_RTI = 8'h80;
   localparam logic [7:0] OP_RTS = 8'h81;
   localparam logic [7:0] OP_SWI = 8'h83;
   localparam logic [7:0] OP_STOP = 8'h8e;
   localparam logic [7:0] OP_WAIT = 8'h8f;
   localparam logic [7:0] OP_TAX = 8'h97;
   localparam logic [7:0] OP_CLC = 8'h98;
   localparam logic [7:0] OP_SEC = 8'h99;
   localparam logic [7:0] OP_CLI = 8'h9a;
   localparam logic [7:0] OP_SEI = 8'h9b;
   localparam logic [7:0] OP_RSP = 8'h9c;
   localparam logic [7:0] OP_NOP = 8'h9d;
   localparam logic [7:0] OP_TXA = 8'h9f;
   // Flag positions in the five-bit condition code register
   localparam int CCR_H = 4;
   localparam int CCR_I = 3;
   localparam int CCR_N = 2;
   localparam int CCR_Z = 1;
   localparam int CCR_C = 0;
   localparam logic [4:0] CCR_RESET = 5'h08;
   localparam logic [2:0] CCR_PAD = 3'h7;
   // Reset values and fixed addresses
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'hff;
   localparam logic [1:0] SP_FIXED = 2'h3;
   localparam logic [15:0] SWI_VEC_ADDR = 16'hfffc;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [2:0] STK_N_JSR = 3'h2;
   localparam logic [2:0] STK_N_SWI = 3'h5;
   localparam logic [1:0] VEC_BYTES = 2'h2;
endpackage

/* File: logic/mcbbcd_alu.sv */
// Arithmetic unit for add-with-carry, logical AND and test
`timescale 1ns/1ns
module mcbbcd_alu (
   input wire mcbbcd_pkg::mcbbcd_alu_t sel,
   input wire logic [7:0] a,
   input wire logic [7:0] m,
   input wire logic cin,
   output logic [7:0] res,
   output logic h,
   output logic n,
   output logic z,
   output logic c
);
   logic [8:0] sum;
   logic [4:0] low;

   always_comb begin
      sum = {1'b0, a} + {1'b0, m} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
      res = m;
      h = 1'b0;
      c = 1'b0;
      unique case (sel)
         mcbbcd_pkg::ALU_ADC: begin
            res = sum[7:0];
            h = low[4];
            c = sum[8];
         end
         mcbbcd_pkg::ALU_AND: begin
            res = a & m;
         end
         mcbbcd_pkg::ALU_TST: begin
            res = m;
         end
         default: begin
            res = m;
         end
      endcase
      n = res[7];
      z = (res == 8'h00);
   end
endmodule

/* File: tb/mcbbcd_assertions.sv */
// Port checker for the branch, bit and control decoder core
`timescale 1ns/1ns
module mcbbcd_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic wake_req,
   input wire logic [15:0] mem_addr_ff,
   input wire logic mem_rd_ff,
   input wire logic mem_wr_ff,
   input wire logic osc_stop_ff,
   input wire logic cpu_halt_ff,
   input wire logic irq_pin_en_ff,
   input wire logic unsup_op_ff,
   input wire logic [15:0] pc_ff,
   input wire logic [7:0] sp_ff,
   input wire logic [4:0] ccr_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence halted;
      cpu_halt_ff || osc_stop_ff;
   endsequence
   sequence woken;
      ##[1:2] !(cpu_halt_ff || osc_stop_ff);
   endsequence
   AST_FETCH_ZERO: assert property ($past(rst, 2) && !$past(rst) |-> mem_rd_ff && mem_addr_ff == 16'h0000)
      else $error("no opcode fetch at zero after reset");
   AST_RD_GAP: assert property (mem_rd_ff |=> !mem_rd_ff)
      else $error("reads in adjacent cycles");
   AST_RD_WR: assert property (!(mem_rd_ff && mem_wr_ff))
      else $error("read and write together");
   AST_WR_PAGE0: assert property (mem_wr_ff |-> mem_addr_ff[15:8] == 8'h00)
      else $error("write above page zero");
   AST_STOP_PIN: assert property (osc_stop_ff == irq_pin_en_ff)
      else $error("stop and pin enable differ");
   AST_WAIT_MASK: assert property (cpu_halt_ff && $past(cpu_halt_ff) |-> !ccr_ff[mcbbcd_pkg::CCR_I])
      else $error("mask set while waiting");
   AST_HALT_PC: assert property (halted ##1 halted |-> $stable(pc_ff))
      else $error("pc moved while halted");
   AST_WAKE: assert property (halted ##0 wake_req |-> woken)
      else $error("no wake");
   AST_SP_PAGE: assert property (sp_ff[7:6] == 2'b11)
      else $error("stack pointer off its page");
   AST_UNSUP_PULSE: assert property (unsup_op_ff |=> !unsup_op_ff)
      else $error("unsupported flag held past one cycle");
endmodule
bind mcbbcd_core mcbbcd_chk u_chk (.clk(clk), .rst(rst), .wake_req(wake_req), .mem_addr_ff(mem_addr_ff),
   .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff), .osc_stop_ff(osc_stop_ff), .cpu_halt_ff(cpu_halt_ff),
   .irq_pin_en_ff(irq_pin_en_ff), .unsup_op_ff(unsup_op_ff), .pc_ff(pc_ff), .sp_ff(sp_ff), .ccr_ff(ccr_ff));

/* File: tb/mcbbcd_mem.sv */
// Behavioural program and data memory on the core's bus
`timescale 1ns/1ns
module mcbbcd_mem (
   input wire logic clk,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic rd,
   input wire logic wr,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:65535];
   // Core latches the byte at the end of its strobe cycle, so the read is combinational
   // Inverted byte when not strobed so a mistimed sample never looks right
   assign rdata = rd ? mem[addr] : ~mem[addr];
   always @(posedge clk) begin
      if (wr) mem[addr] <= wdata;
   end
endmodule

/* File: tb/mcbbcd_core_test.sv */
// Self-checking bench for the decoder core
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %h seen %h", nm, e, g); end end
module mcbbcd_core_test;
   logic clk = 1'b0, rst = 1'b1, irq_pin = 1'b0, wake_req = 1'b0, hq = 1'b0, un = 1'b0;
   logic [15:0] mem_addr_ff, pc_ff, t, ea;
   logic [7:0] mem_wdata_ff, mem_rdata, sp_ff, acc_ff, idx_ff, r1, r2, v, op, d, nv, res;
   logic [4:0] ccr_ff, hs, cc;
   logic mem_rd_ff, mem_wr_ff, osc_stop_ff, cpu_halt_ff, irq_pin_en_ff, unsup_op_ff, p, q, tk;
   logic [8:0] s;
   logic [2:0] b;
   logic [49:0] nt, notes[$];
   logic [15:0] otab [0:5] = '{16'h0000, 16'h0080, 16'h1234, 16'h1000, 16'h0040, 16'h0000};
   int klen [0:5] = '{1, 1, 2, 2, 1, 0};
   int n_fail = 0, num_checks = 0, wrs = 0, i, m;
   mcbbcd_core u_mcbbcd_core (.clk(clk), .rst(rst), .mem_rdata(mem_rdata), .irq_pin(irq_pin), .wake_req(wake_req),
      .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
      .osc_stop_ff(osc_stop_ff), .cpu_halt_ff(cpu_halt_ff), .irq_pin_en_ff(irq_pin_en_ff), .unsup_op_ff(unsup_op_ff),
      .pc_ff(pc_ff), .sp_ff(sp_ff), .acc_ff(acc_ff), .idx_ff(idx_ff), .ccr_ff(ccr_ff));
   mcbbcd_mem m0 (.clk(clk), .addr(mem_addr_ff), .wdata(mem_wdata_ff), .rd(mem_rd_ff), .wr(mem_wr_ff),
      .rdata(mem_rdata));
   always #25 clk = ~clk;
   // Note taken off on the first halted cycle
   always @(posedge clk) begin
      hq <= cpu_halt_ff | osc_stop_ff;
      wrs <= rst ? 0 : wrs + int'(mem_wr_ff);
      un <= rst ? 1'b0 : un | unsup_op_ff;
      if (!rst && (cpu_halt_ff | osc_stop_ff) && !hq) begin
         if (notes.size() == 0) n_fail++;
         nt = notes.size() > 0 ? notes.pop_front() : 50'h0;
         `CHK("unsup", nt[49], un)
         `CHK("acc", nt[48:41], acc_ff)
         `CHK("idx", nt[40:33], idx_ff)
         `CHK("ccr", nt[32:28], ccr_ff)
         `CHK("pc", nt[27:12], pc_ff)
         `CHK("m60", nt[11:4], m0.mem[16'h0060])
         `CHK("writes", nt[3:0], wrs[3:0])
      end
   end
   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic prog(input logic [15:0] a, input logic [63:0] dt, input int n);
      for (int j = 0; j < n; j++) m0.mem[a + 16'(j)] = dt[8 * (n - 1 - j) +: 8];
   endtask
   // Runs from reset until halt; leaves the core in reset so loading is safe
   task automatic run(input logic [49:0] x);
      int k;
      notes.push_back(x);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (k = 0; k < 400 && cpu_halt_ff !== 1'b1 && osc_stop_ff !== 1'b1; k++) @(negedge clk);
      if (k == 400) begin
         n_fail++;
         report_and_stop();
      end
      repeat (2) @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk) wake_req <= 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b1;
      $display("test done, %0d checks", num_checks);
   endtask
   initial begin
      void'($urandom(32'hb343_0552));
      m0.mem[16'h0060] = 8'h00;
      repeat (5) @(posedge clk);
      for (i = 0; i < 12; i++) begin
         m = i / 2;
         r1 = 8'($urandom) | 8'h20;
         r2 = 8'($urandom);
         op = {4'ha + 4'(m), i[0] ? 4'h4 : 4'h9};
         ea = otab[m] + (m >= 3 ? {8'h00, r1} : 16'h0000);
         m0.mem[ea] = r2;
         prog(16'h0000, {8'h98, 8'ha9, r1, 8'h97, 8'h99, op}, 6);
         prog(16'h0006, {m == 0 ? {8'h00, r2} : otab[m], 8'h8f}, klen[m] + 1);
         s = {1'b0, r1} + {1'b0, r2} + 9'h001;
         hs = {1'b0, r1[3:0]} + {1'b0, r2[3:0]} + 5'h01;
         res = i[0] ? r1 & r2 : s[7:0];
         cc = i[0] ? {2'b00, res[7], res == 8'h00, 1'b1} : {hs[4], 1'b0, res[7], res == 8'h00, s[8]};
         run({res, r1, cc, 16'(7 + klen[m]), m0.mem[16'h0060], 4'h0});
      end
      // Both displacement extremes, random bit and polarity
      for (i = 0; i < 8; i++) begin
         {b, p, v} = 12'($urandom);
         d = i[0] ? 8'h7f : 8'h80;
         t = 16'h0003 + {{8{d[7]}}, d};
         prog(16'h0000, {{4'h0, b, p}, 8'h50, d, 8'h8f}, 4);
         prog(t, 64'h8f, 1);
         m0.mem[16'h0050] = v;
         run({16'h0000, {4'h0, v[b]}, (v[b] ^ p) ? t + 16'h0001 : 16'h0004, m0.mem[16'h0060], 4'h0});
      end
      for (i = 0; i < 6; i++) begin
         {p, q} = 2'($urandom);
         irq_pin <= q;
         op = 8'h28 + 8'(i < 2 ? i : i + 2);
         tk = ({q, !q, !p, p, 2'b01} >> i) & 1'b1;
         prog(16'h0000, {p ? 8'h9a : 8'h9d, op, 8'h10, 8'h8f}, 4);
         prog(16'h0013, 64'h8f, 1);
         run({21'h0, tk ? 16'h0014 : 16'h0004, m0.mem[16'h0060], 4'h0});
      end
      for (i = 0; i < 8; i++) begin
         {b, p, v} = 12'($urandom);
         m0.mem[16'h0060] = v;
         nv = v;
         nv[b] = !p;
         // Unknown inherent opcode before stop must pulse the flag and act as a no-op
         prog(16'h0000, {{4'h1, b, p}, 8'h60, 8'h3d, 8'h60, 8'h9e, 8'h8e}, 6);
         run({1'b1, 16'h0000, {2'b01, nv[7], nv == 8'h00, 1'b0}, 16'h0006, nv, 4'h1});
      end
      report_and_stop();
   end
endmodule
